// File: pcr_defs.svh
// register offsets, field positions, reset values and record constants of the capture recorder
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

`define PCR_CTRL_OFS 8'h00
`define PCR_SLEN_OFS 8'h04
`define PCR_STATUS_OFS 8'h08
`define PCR_PORTA_SEL 3'h1
`define PCR_PORTB_SEL 3'h2
`define PCR_FLAGS_OFS 5'h00
`define PCR_ANEG_OFS 5'h04
`define PCR_BADSYM_OFS 5'h08
`define PCR_CRC_OFS 5'h0C
`define PCR_REMOTE_OFS 5'h10
`define PCR_BYTES_OFS 5'h14
`define PCR_FRAMES_OFS 5'h18

`define PCR_CTRL_EN_A 0
`define PCR_CTRL_EN_B 1
`define PCR_CTRL_VARLEN 2
`define PCR_CTRL_DEFAULTS 3
`define PCR_STAT_ACTIVE 0
`define PCR_STAT_DROPPING 1
`define PCR_STAT_BUSY 2
`define PCR_STAT_LOSS_LSB 16

`define PCR_EN_RST 2'h3
`define PCR_VARLEN_RST 1'b1
`define PCR_SLEN_MIN 11'd16
`define PCR_SLEN_MAX 11'd1536
`define PCR_SLEN_RST 11'd1536
`define PCR_HDR_WORDS 10'd4
`define PCR_REC_EXTRA_WORDS 10'd5

`endif

// File: pcr_pkg.sv
// types shared by the capture recorder modules
package pcr_pkg;
  `include "pcr_defs.svh"

  typedef enum logic [1:0] {
    pcr_st_idle = 2'b00,
    pcr_st_recv = 2'b01,
    pcr_st_emit = 2'b11
  } pcr_state_type;

  typedef struct packed {
    logic [31:0] bad_sym;
    logic [31:0] crc_fail;
    logic [31:0] remote;
    logic [31:0] bytes;
    logic [31:0] frames;
    logic [3:0] flags;
  } pcr_stats_state_type;
endpackage : pcr_pkg

// File: pcr_stat_if.sv
// carrier between the recorder top and one port's statistics block
`timescale 1ns/1ns
`default_nettype none
interface pcr_stat_if;
  logic sym_err;
  logic crc_err;
  logic remote_err;
  logic byte_ok;
  logic frame_ok;
  logic [3:0] link;
  logic [3:0] flag_clr;
  logic [31:0] bad_sym_cnt;
  logic [31:0] crc_cnt;
  logic [31:0] remote_cnt;
  logic [31:0] byte_cnt;
  logic [31:0] frame_cnt;
  logic [3:0] flags;

  modport src (
    output sym_err, crc_err, remote_err, byte_ok, frame_ok, link, flag_clr,
    input bad_sym_cnt, crc_cnt, remote_cnt, byte_cnt, frame_cnt, flags
  );
  modport stats (
    input sym_err, crc_err, remote_err, byte_ok, frame_ok, link, flag_clr,
    output bad_sym_cnt, crc_cnt, remote_cnt, byte_cnt, frame_cnt, flags
  );
endinterface : pcr_stat_if
`default_nettype wire

// File: pcr_port_stats.sv
// per-port link statistics: error, byte and frame counters plus sticky link flags
`timescale 1ns/1ns
`default_nettype none
module pcr_port_stats (
  input wire logic clk_in,
  input wire logic rst_n_in,
  pcr_stat_if.stats sif
);
  import pcr_pkg::*;

  pcr_stats_state_type r;
  pcr_stats_state_type next_r;

  always_comb begin
    next_r = r;
    if (sif.sym_err) begin
      next_r.bad_sym = r.bad_sym + 32'h1; // [R01]
    end
    if (sif.crc_err) begin
      next_r.crc_fail = r.crc_fail + 32'h1; // [R02]
    end
    if (sif.remote_err) begin
      next_r.remote = r.remote + 32'h1; // [R03]
    end
    if (sif.byte_ok) begin
      next_r.bytes = r.bytes + 32'h1; // [R04]
    end
    if (sif.frame_ok) begin
      next_r.frames = r.frames + 32'h1; // [R04]
    end
    // only bits already reported are cleared, and a level present now re-sets them
    next_r.flags = (r.flags & ~sif.flag_clr) | sif.link; // [R05] [R06]
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sif.bad_sym_cnt = r.bad_sym;
  assign sif.crc_cnt = r.crc_fail;
  assign sif.remote_cnt = r.remote;
  assign sif.byte_cnt = r.bytes;
  assign sif.frame_cnt = r.frames;
  assign sif.flags = r.flags;
endmodule : pcr_port_stats
`default_nettype wire

// File: pcr_top.sv
// two-port frame capture recorder: record builder, per-port statistics and register slave
// Function
// [R01] Each port counts every invalid line symbol it receives.
// [R02] Each port counts every received frame whose check sequence fails.
// [R03] Each port counts every error indication propagated by the link peer.
// [R04] Each port counts received bytes and received frames.
// [R05] Link status flags hold any occurrence since the previous read of them.
// [R06] Signal-lost and framing-lost flags follow the receiver's optical and framing detectors.
// [R07] The capture length takes values 16 to 1536 and is rounded down to a multiple of 4.
// [R08] Restoring defaults sets the capture length to 1536.
// [R09] In variable mode a longer frame is cut to the capture length.
// [R10] In variable mode a shorter frame gives a shorter record without padding.
// [R11] In fixed mode every record carries exactly the capture length, cut or zero padded.
// [R12] Each record starts with a 16-byte header and ends with 4 bytes of alignment padding.
// [R13] Each port can be enabled on its own and a disabled port yields no records.
// [R14] Each captured frame yields one record towards host memory.
// [R15] Frames arriving while the host buffer is full are discarded until space frees up.
// [R16] The capture-in-progress output is low while frames are being discarded.
// [R17] Discarded frames are counted in the loss field of later records.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pcr_top #(
  parameter int MAX_WORDS = 384
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [1:0] rx_valid_in,
  input wire logic [1:0][7:0] rx_data_in,
  input wire logic [1:0] rx_last_in,
  input wire logic [1:0] rx_crc_bad_in,
  input wire logic [1:0] rx_sym_err_in,
  input wire logic [1:0] rx_remote_err_in,
  input wire logic [1:0] local_link_up_flag_in,
  input wire logic [1:0] peer_link_up_flag_in,
  input wire logic [1:0] signal_lost_flag_in,
  input wire logic [1:0] framing_lost_flag_in,
  input wire logic [1:0][15:0] autoneg_word_received_in,
  input wire logic host_full_in,
  input wire logic rec_ready_in,
  output logic rec_valid_out,
  output logic [31:0] rec_data_out,
  output logic rec_last_out,
  output logic capture_active_out
);
  import pcr_pkg::*;

  localparam int AW = $clog2(MAX_WORDS);

  typedef struct packed {
    pcr_state_type state;
    logic [1:0] en;
    logic varlen;
    logic [10:0] slen;
    logic sel;
    logic [15:0] len;
    logic [31:0] asm_word;
    logic [9:0] wr_words;
    logic crc_bad;
    logic [9:0] cap_words;
    logic [9:0] idx;
    logic rec_valid;
    logic [31:0] rec_data;
    logic rec_last;
    logic [15:0] loss;
    logic [15:0] hdr_loss;
    logic [31:0] seq;
    logic dropping;
    logic cap_active;
    logic [1:0] in_frame;
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0][3:0] flag_clr;
  } pcr_top_state_type;

  localparam pcr_top_state_type RESET_STATE = '{
    state: pcr_st_idle, en: `PCR_EN_RST, varlen: `PCR_VARLEN_RST, slen: `PCR_SLEN_RST,
    waitreq: 1'b1, default: '0};

  function automatic logic [31:0] pcr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] mask;
    mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~mask) | (new_v & mask);
  endfunction : pcr_merge

  function automatic logic [10:0] pcr_round_slen(input logic [31:0] v);
    logic [10:0] c;
    if (v < 32'(`PCR_SLEN_MIN)) begin
      c = `PCR_SLEN_MIN;
    end else if (v > 32'(`PCR_SLEN_MAX)) begin
      c = `PCR_SLEN_MAX;
    end else begin
      c = v[10:0];
    end
    return c & ~11'h003; // [R07]
  endfunction : pcr_round_slen

  logic rst_meta;
  logic rst_sync;
  pcr_top_state_type r;
  pcr_top_state_type next_r;
  logic [31:0] mem [MAX_WORDS];
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [1:0] sof;
  logic start;
  logic sp;
  logic cur;
  logic take;
  logic [1:0] drop_inc;
  logic loss_clr;
  logic [15:0] blen;
  logic [31:0] basm;
  logic [9:0] bwr;
  logic [31:0] aw;
  logic [9:0] total;
  logic [9:0] pidx;
  logic [31:0] word;
  logic [31:0] rd_word;
  logic [31:0] wd;
  logic [16:0] loss_sum;
  logic [1:0][31:0] cnt_bad;
  logic [1:0][31:0] cnt_crc;
  logic [1:0][31:0] cnt_remote;
  logic [1:0][31:0] cnt_bytes;
  logic [1:0][31:0] cnt_frames;
  logic [1:0][3:0] flags;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  for (genvar gp = 0; gp < 2; gp++) begin : g_port
    pcr_stat_if sif ();
    assign sif.sym_err = rx_sym_err_in[gp];
    assign sif.crc_err = rx_valid_in[gp] && rx_last_in[gp] && rx_crc_bad_in[gp];
    assign sif.remote_err = rx_remote_err_in[gp];
    assign sif.byte_ok = rx_valid_in[gp];
    assign sif.frame_ok = rx_valid_in[gp] && rx_last_in[gp];
    assign sif.link = {framing_lost_flag_in[gp], signal_lost_flag_in[gp],
                       peer_link_up_flag_in[gp], local_link_up_flag_in[gp]};
    assign sif.flag_clr = r.flag_clr[gp];
    assign cnt_bad[gp] = sif.bad_sym_cnt;
    assign cnt_crc[gp] = sif.crc_cnt;
    assign cnt_remote[gp] = sif.remote_cnt;
    assign cnt_bytes[gp] = sif.byte_cnt;
    assign cnt_frames[gp] = sif.frame_cnt;
    assign flags[gp] = sif.flags;
    pcr_port_stats u_stats (
      .clk_in(clk_in),
      .rst_n_in(rst_sync),
      .sif(sif.stats)
    );
  end

  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    mem_addr = '0;
    mem_wdata = '0;
    start = 1'b0;
    sp = 1'b0;
    drop_inc = 2'h0;
    loss_clr = 1'b0;
    aw = '0;
    word = '0;
    rd_word = '0;
    wd = '0;
    for (int p = 0; p < 2; p++) begin
      sof[p] = rx_valid_in[p] && !r.in_frame[p];
      if (rx_valid_in[p]) begin
        next_r.in_frame[p] = !rx_last_in[p];
      end
      // a disabled port is tracked for framing but never opens a record
      if (sof[p] && r.en[p]) begin // [R13]
        if (r.state == pcr_st_idle && !host_full_in && !start) begin
          start = 1'b1;
          sp = 1'(p);
        end else begin
          drop_inc = drop_inc + 2'h1; // [R15]
        end
      end
    end
    cur = start ? sp : r.sel;
    take = start || (r.state == pcr_st_recv && rx_valid_in[r.sel]);
    blen = start ? 16'h0 : r.len;
    basm = start ? 32'h0 : r.asm_word;
    bwr = start ? 10'h0 : r.wr_words;
    if (start) begin
      next_r.state = pcr_st_recv;
      next_r.sel = sp;
      next_r.crc_bad = 1'b0;
      next_r.wr_words = 10'h0;
      next_r.asm_word = 32'h0;
    end
    if (take) begin
      // bytes past the capture length are counted but not stored
      if (blen < {5'h0, r.slen}) begin // [R09] [R11]
        aw = basm;
        aw[{blen[1:0], 3'b000} +: 8] = rx_data_in[cur];
        if (blen[1:0] == 2'h3 || rx_last_in[cur]) begin
          mem_we = 1'b1;
          mem_addr = bwr[AW-1:0];
          mem_wdata = aw;
          next_r.wr_words = bwr + 10'h1;
          next_r.asm_word = 32'h0;
        end else begin
          next_r.asm_word = aw;
        end
      end
      next_r.len = (blen == 16'hFFFF) ? blen : blen + 16'h1;
      if (rx_last_in[cur]) begin
        next_r.crc_bad = rx_crc_bad_in[cur];
        next_r.state = pcr_st_emit; // [R14]
        next_r.idx = 10'h0;
        next_r.cap_words = r.varlen ? next_r.wr_words : {1'b0, r.slen[10:2]}; // [R10] [R11]
        next_r.hdr_loss = r.loss; // [R17]
        loss_clr = 1'b1;
      end
    end
    total = r.cap_words + `PCR_REC_EXTRA_WORDS; // [R12]
    pidx = r.idx - `PCR_HDR_WORDS;
    unique case (r.idx)
      10'h0: word = r.seq;
      10'h1: word = {7'h0, r.sel, 5'h0, r.len > {5'h0, r.slen}, r.varlen, r.crc_bad,
                     6'h0, total};
      10'h2: word = {r.hdr_loss, r.len};
      10'h3: word = 32'h0;
      default: word = (pidx < r.wr_words) ? mem[pidx[AW-1:0]] : 32'h0; // [R11] [R12]
    endcase
    if (r.state == pcr_st_emit && (!r.rec_valid || rec_ready_in)) begin
      if (r.idx == total) begin
        next_r.rec_valid = 1'b0;
        next_r.rec_last = 1'b0;
        next_r.state = pcr_st_idle;
        next_r.seq = r.seq + 32'h1;
      end else begin
        next_r.rec_valid = 1'b1;
        next_r.rec_data = word;
        next_r.rec_last = (r.idx == total - 10'h1);
        next_r.idx = r.idx + 10'h1;
      end
    end
    // a drop in the very cycle the count is handed to a header goes to the next record
    loss_sum = {1'b0, loss_clr ? 16'h0 : r.loss} + {15'h0, drop_inc}; // [R17]
    next_r.loss = loss_sum[16] ? 16'hFFFF : loss_sum[15:0];
    if (drop_inc != 2'h0) begin
      next_r.dropping = 1'b1;
    end else if (start) begin
      next_r.dropping = 1'b0;
    end
    next_r.flag_clr = '0;
    if (avs_address_in == `PCR_CTRL_OFS) begin
      rd_word = {29'h0, r.varlen, r.en};
    end else if (avs_address_in == `PCR_SLEN_OFS) begin
      rd_word = {21'h0, r.slen};
    end else if (avs_address_in == `PCR_STATUS_OFS) begin
      rd_word = {r.loss, 13'h0, r.state != pcr_st_idle, r.dropping, r.cap_active};
    end
    for (int p = 0; p < 2; p++) begin
      if (avs_address_in[7:5] == `PCR_PORTA_SEL + 3'(p)) begin
        unique case (avs_address_in[4:0])
          `PCR_FLAGS_OFS: rd_word = {28'h0, flags[p]};
          `PCR_ANEG_OFS: rd_word = {16'h0, autoneg_word_received_in[p]};
          `PCR_BADSYM_OFS: rd_word = cnt_bad[p];
          `PCR_CRC_OFS: rd_word = cnt_crc[p];
          `PCR_REMOTE_OFS: rd_word = cnt_remote[p];
          `PCR_BYTES_OFS: rd_word = cnt_bytes[p];
          `PCR_FRAMES_OFS: rd_word = cnt_frames[p];
          default: rd_word = 32'h0;
        endcase
      end
    end
    next_r.waitreq = !((avs_read_in || avs_write_in) && r.waitreq);
    if (avs_read_in && r.waitreq) begin
      next_r.rdata = rd_word;
    end
    if (avs_read_in && !r.waitreq) begin
      for (int p = 0; p < 2; p++) begin
        if (avs_address_in == {`PCR_PORTA_SEL + 3'(p), `PCR_FLAGS_OFS}) begin
          next_r.flag_clr[p] = r.rdata[3:0]; // [R05]
        end
      end
    end
    if (avs_write_in && !r.waitreq) begin
      if (avs_address_in == `PCR_CTRL_OFS) begin
        wd = pcr_merge({29'h0, r.varlen, r.en}, avs_writedata_in, avs_byteenable_in);
        next_r.en = {wd[`PCR_CTRL_EN_B], wd[`PCR_CTRL_EN_A]}; // [R13]
        next_r.varlen = wd[`PCR_CTRL_VARLEN];
        if (wd[`PCR_CTRL_DEFAULTS]) begin
          next_r.en = `PCR_EN_RST;
          next_r.varlen = `PCR_VARLEN_RST;
          next_r.slen = `PCR_SLEN_RST; // [R08]
        end
      end else if (avs_address_in == `PCR_SLEN_OFS) begin
        wd = pcr_merge({21'h0, r.slen}, avs_writedata_in, avs_byteenable_in);
        next_r.slen = pcr_round_slen(wd); // [R07]
      end
    end
    next_r.cap_active = (|next_r.en) && !host_full_in && !next_r.dropping; // [R16]
  end

  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata_out = r.rdata;
  assign avs_waitrequest_out = r.waitreq;
  assign rec_valid_out = r.rec_valid;
  assign rec_data_out = r.rec_data;
  assign rec_last_out = r.rec_last;
  assign capture_active_out = r.cap_active;
endmodule : pcr_top
`default_nettype wire

// File: pcr_host_model.sv
// host buffer model: takes record words, can stall and can report itself full
`timescale 1ns/1ns
`default_nettype none
module pcr_host_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rec_valid_in,
  input wire logic [31:0] rec_data_in,
  input wire logic rec_last_in,
  input wire logic full_cmd_in,
  input wire logic slow_in,
  output logic rec_ready_out,
  output logic host_full_out
);
  logic [31:0] mem [0:511];
  int idx;
  int nwords;
  int nrecs;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_ready_out <= 1'b0;
      host_full_out <= 1'b0;
      idx <= 0;
      nwords <= 0;
      nrecs <= 0;
    end else begin
      // a slow reader takes a word only every other cycle
      rec_ready_out <= slow_in ? !rec_ready_out : 1'b1;
      host_full_out <= full_cmd_in;
      if (rec_valid_in && rec_ready_out) begin
        mem[idx] <= rec_data_in;
        idx <= rec_last_in ? 0 : idx + 1;
        if (rec_last_in) begin
          nwords <= idx + 1;
          nrecs <= nrecs + 1;
        end
      end
    end
  end
endmodule : pcr_host_model
`default_nettype wire

// File: pcr_monitor.sv
// assertions and covers on the capture recorder top ports
`timescale 1ns/1ns
`default_nettype none
module pcr_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic host_full_in,
  input wire logic rec_ready_in,
  input wire logic rec_valid_out,
  input wire logic [31:0] rec_data_out,
  input wire logic rec_last_out,
  input wire logic capture_active_out
);
  logic [15:0] wcnt;
  logic [15:0] rlen;
  wire logic hs = rec_valid_out && rec_ready_in;
  // word count of the record in flight, length field latched from word 1
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wcnt <= 16'h0000;
      rlen <= 16'h0000;
    end else if (hs) begin
      wcnt <= rec_last_out ? 16'h0000 : wcnt + 16'h0001;
      if (wcnt == 16'h0001) begin
        rlen <= rec_data_out[15:0];
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer late");
  chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  chk_rdata_hold: assert property ((avs_waitrequest_out || !avs_read_in)
    |-> $stable(avs_readdata_out)) else $error("read data moved");
  chk_unmapped_zero: assert property (avs_read_in && avs_waitrequest_out
    && avs_address_in == 8'hFC |=> avs_readdata_out == 32'h0) else $error("unmapped nonzero");
  chk_rec_hold: assert property (rec_valid_out && !rec_ready_in
    |=> rec_valid_out && $stable(rec_data_out) && $stable(rec_last_out)) else $error("word lost");
  chk_last_valid: assert property (rec_last_out |-> rec_valid_out)
    else $error("last without valid");
  // the length field counts record words, header and closing word included
  chk_rec_length: assert property (hs && rec_last_out
    |-> rlen == wcnt + 16'h0001) else $error("record length field wrong");
  chk_full_idle: assert property (host_full_in |=> !capture_active_out)
    else $error("active while full");
  cov_record: cover property (hs && rec_last_out);
  cov_full: cover property (host_full_in ##1 !capture_active_out);
  cov_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule : pcr_monitor
bind pcr_top pcr_monitor mon_u (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .host_full_in(host_full_in),
  .rec_ready_in(rec_ready_in),
  .rec_valid_out(rec_valid_out),
  .rec_data_out(rec_data_out),
  .rec_last_out(rec_last_out),
  .capture_active_out(capture_active_out)
);
`default_nettype wire

// File: testbench.sv
// self-checking bench for the capture recorder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pcr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] rx_valid = 2'h0;
  logic [1:0][7:0] rx_data = 16'h0;
  logic [1:0] rx_last = 2'h0;
  logic [1:0] rx_crc = 2'h0;
  logic [1:0] rx_sym = 2'h0;
  logic [1:0] rx_rem = 2'h0;
  logic [1:0] sig_lost = 2'h0;
  logic full_cmd = 1'b0;
  logic slow = 1'b0;
  logic host_full;
  logic rec_ready;
  logic rec_valid;
  logic [31:0] rec_data;
  logic rec_last;
  logic active;
  int miscompares = 0;
  int checks_done = 0;
  int sv[3] = '{7, 2000, 75};
  int ex[3] = '{16, 1536, 72};
  always #4 clk_in = ~clk_in;
  pcr_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_last_in(rx_last),
    .rx_crc_bad_in(rx_crc), .rx_sym_err_in(rx_sym), .rx_remote_err_in(rx_rem),
    .local_link_up_flag_in(2'h3), .peer_link_up_flag_in(2'h3),
    .signal_lost_flag_in(sig_lost), .framing_lost_flag_in(2'h0),
    .autoneg_word_received_in(32'h0), .host_full_in(host_full), .rec_ready_in(rec_ready),
    .rec_valid_out(rec_valid), .rec_data_out(rec_data), .rec_last_out(rec_last),
    .capture_active_out(active));
  pcr_host_model host_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .rec_valid_in(rec_valid),
    .rec_data_in(rec_data), .rec_last_in(rec_last), .full_cmd_in(full_cmd),
    .slow_in(slow), .rec_ready_out(rec_ready), .host_full_out(host_full));
  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      miscompares++;
      report_and_stop();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : put
  task automatic get(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : get
  task automatic frame(input int p, input int len, input logic bad);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_in);
      rx_valid[p] <= 1'b1;
      rx_data[p] <= i[7:0];
      rx_last[p] <= (i == len - 1);
      rx_crc[p] <= bad;
    end
    @(posedge clk_in);
    rx_valid <= 2'h0;
    rx_last <= 2'h0;
    rx_crc <= 2'h0;
  endtask : frame
  // waits for the record count, then a quiet spell to catch stray records
  task automatic recs(input int n);
    int k;
    k = 0;
    while (host_u.nrecs != n && k < 3000) begin
      @(posedge clk_in);
      k++;
    end
    repeat (50) @(posedge clk_in);
    check(host_u.nrecs, n);
    if (k >= 3000) report_and_stop();
  endtask : recs
  task automatic hdr(input int nw, input logic [31:0] w1, input logic [31:0] w2);
    check(host_u.nwords, nw);
    check(host_u.mem[1], w1);
    check(host_u.mem[2], w2);
  endtask : hdr
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    get(8'h00, 32'h7);
    get(8'h04, 32'd1536);
    get(8'hFC, 32'h0);
    for (int i = 0; i < 3; i++) begin
      put(8'h04, sv[i]);
      get(8'h04, ex[i]);
    end
    frame(0, 100, 1'b0);
    recs(1);
    hdr(23, 32'h00060017, 32'h00000064);
    check(host_u.mem[4], 32'h03020100);
    get(8'h34, 32'd100);
    get(8'h38, 32'd1);
    slow <= 1'b1;
    frame(1, 30, 1'b0);
    recs(2);
    hdr(13, 32'h0102000D, 32'h0000001E);
    slow <= 1'b0;
    put(8'h00, 32'h3);
    frame(0, 30, 1'b1);
    recs(3);
    hdr(23, 32'h00010017, 32'h0000001E);
    check(host_u.mem[11], 32'h00001D1C);
    check(host_u.mem[21], 32'h0);
    get(8'h2C, 32'd1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      rx_sym[0] <= (i < 3);
      rx_rem[0] <= (i < 2);
      sig_lost[0] <= (i == 0);
    end
    @(posedge clk_in);
    rx_sym <= 2'h0;
    rx_rem <= 2'h0;
    get(8'h28, 32'd3);
    get(8'h30, 32'd2);
    get(8'h20, 32'h7);
    get(8'h20, 32'h3);
    put(8'h00, 32'h6);
    frame(0, 40, 1'b0);
    recs(3);
    put(8'h00, 32'h7);
    full_cmd <= 1'b1;
    repeat (3) @(posedge clk_in);
    frame(0, 20, 1'b0);
    check(active, 1'b0);
    get(8'h08, 32'h00010002);
    recs(3);
    full_cmd <= 1'b0;
    repeat (3) @(posedge clk_in);
    frame(0, 20, 1'b0);
    recs(4);
    hdr(10, 32'h0002000A, 32'h00010014);
    check(host_u.mem[0], 32'd3);
    // clear both enables and variable mode first so the defaults write has something to restore
    put(8'h00, 32'h0);
    put(8'h00, 32'h8);
    get(8'h00, 32'h7);
    get(8'h04, 32'd1536);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
